/* hw/sleep_ctl_pkg.sv */
// Shared constants, register map and types for the end device sleep controller
package sleep_ctl_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLOCK_HZ      = 25_000_000;         // System clock rate
	localparam int unsigned TICK_MS       = 1;                  // Timer tick period in ms
	localparam int unsigned TICK_CYCLES   = CLOCK_HZ / 1000 * TICK_MS; // Cycles per tick
	localparam int unsigned POLL_MS       = 100;                // Poll interval while awake
	localparam logic [6:0]  POLL_RELOAD   = 7'(POLL_MS / TICK_MS - 1); // One less than ticks between polls

	// ************************************************************
	// Sleep mode codes
	// ************************************************************
	localparam logic [2:0] MODE_PIN       = 3'h1;               // Pin-controlled sleep
	localparam logic [2:0] MODE_CYCLIC    = 3'h4;               // Timed sleep, pin ignored
	localparam logic [2:0] MODE_CYC_PIN   = 3'h5;               // Timed sleep, pin may wake

	// ************************************************************
	// APB register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL       = 8'h00;              // Control bits
	localparam logic [7:0] OFS_WAKE_TIME  = 8'h04;              // Cyclic wake time, ms
	localparam logic [7:0] OFS_SLEEP_PER  = 8'h08;              // Cyclic sleep period, ms
	localparam logic [7:0] OFS_CHILD_TO   = 8'h0C;              // Child timeout setting
	localparam logic [7:0] OFS_SCAN_MASK  = 8'h10;              // Scan channel mask
	localparam logic [7:0] OFS_STATUS     = 8'h14;              // Read-only status

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [9:0]  RST_CTRL      = 10'h020;            // Mode 0, sleep pin enabled
	localparam logic [15:0] RST_WAKE_TIME = 16'h00C8;           // Default wake time
	localparam logic [15:0] RST_SLEEP_PER = 16'h03E8;           // Default sleep period
	localparam logic [7:0]  RST_CHILD_TO  = 8'h01;              // Default child timeout
	localparam logic [15:0] RST_SCAN_MASK = 16'hFFFF;           // All channels

	// ************************************************************
	// Types
	// ************************************************************
	// Control register layout, bit 0 upward from the right
	typedef struct packed {
		logic       periph_pin_c_config;       // Bit 9
		logic       periph_pin_b_config;       // Bit 8
		logic       periph_pin_a_config;       // Bit 7
		logic       alt_select_pin_config;     // Bit 6
		logic       sleep_request_pin_config;  // Bit 5
		logic       assoc_indicator_config;    // Bit 4
		logic       flow_control_pin_config;   // Bit 3
		logic [2:0] sleep_mode_select;         // Bits 2:0
	} ctrl_type;

	// Poll acknowledgment from the radio logic
	typedef struct packed {
		logic valid;                           // Ack received this cycle
		logic pending;                         // Parent holds data
	} ack_type;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_AWAKE = 3'b001,
		ST_DRAIN = 3'b010,
		ST_SLEEP = 3'b100
	} state_type;

endpackage

/* hw/tick_divider.sv */
// Restartable divider producing a one-cycle timer tick enable
module tick_divider
	import sleep_ctl_pkg::*;
#(
	parameter int unsigned DIVIDE = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Control
	input  wire logic i_restart,
	// Tick out
	output logic      o_tick
);

	// ************************************************************
	// Divider counter
	// ************************************************************
	logic [31:0] count_ff;                     // Cycles since last tick

	// Count up, tick at terminal value, restart zeroes the phase
	always_ff @(posedge i_clock) begin
		if (i_srst || i_restart) begin
			count_ff <= 32'h0000_0000;
			o_tick   <= 1'b0;
		end else if (count_ff == 32'(DIVIDE - 1)) begin
			count_ff <= 32'h0000_0000;
			o_tick   <= 1'b1;
		end else begin
			count_ff <= count_ff + 32'h0000_0001;
			o_tick   <= 1'b0;
		end
	end

endmodule

/* hw/sleep_ctl.sv */
// Sleep and wake sequencer for a mesh end device, with APB registers
//
// Contract
// RULE1: parent drops child missing poll timeout
// RULE2: send child timeout to parent on join
// RULE3: mode 1 selects pin sleep
// RULE4: modes 4 and 5 select cyclic sleep
// RULE5: mode 4 ignores pin as wake source
// RULE6: mode 5 pin fall wakes, holds wake time
// RULE7: stay awake while host holds line low
// RULE8: poll parent every 100 ms while awake
// RULE9: receiver on until ack, then per pending
// RULE10: awake indicator low on sleep
// RULE11: clear-to-send high on sleep if enabled
// RULE12: association indicator low while asleep if enabled
// RULE13: sleep request pin pulled down while asleep
// RULE14: ignore serial and radio data while asleep
// RULE15: restore indicators on wake
// RULE16: scan channel mask on wake if unjoined
// RULE17: finish transfer or join before sleeping
// RULE18: pin sleep wakes when line low
// RULE19: alternate select pin may replace sleep line
// RULE20: first poll within 1-2 ms of wake
// RULE21: cyclic wake sleeps again unless data
// RULE22: senders use extended retry for end devices
// RULE23: poll timer restarts on each wake
module sleep_ctl
	import sleep_ctl_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Pins from host
	input  wire logic        i_sleep_request_line,
	input  wire logic        i_alt_select_pin,
	// Radio and serial logic, same clock
	input  wire logic        i_joined,
	input  wire logic        i_busy,
	input  wire ack_type     i_poll_ack,
	input  wire logic        i_rx_done,
	input  wire logic        i_data_seen,
	input  wire logic        i_assoc_led,
	// Radio requests
	output logic             o_poll_req,
	output logic             o_rx_on,
	output logic             o_scan_req,
	output logic [15:0]      o_scan_mask,
	output logic             o_timeout_send,
	output logic [7:0]       o_child_timeout,
	output logic             o_accept_data,
	// Pins to host
	output logic             o_awake,
	output logic             o_cts_n,
	output logic             o_assoc,
	output logic             o_sleep_pin_pulldown
);

	// ************************************************************
	// Registers and state
	// ************************************************************
	ctrl_type    ctrl_ff;                      // Control register
	logic [15:0] wake_time_ff;                 // Cyclic wake time, ticks
	logic [15:0] sleep_per_ff;                 // Cyclic sleep period, ticks
	logic [7:0]  child_to_ff;                  // Child timeout setting
	logic [15:0] scan_mask_ff;                 // Channels to scan
	state_type   state_ff;                     // Sequencer state
	state_type   nxt_state;                    // Next sequencer state
	logic        req_meta_ff;                  // Sleep line, first stage
	logic        req_sync_ff;                  // Sleep line, synchronised
	logic        alt_meta_ff;                  // Alternate pin, first stage
	logic        alt_sync_ff;                  // Alternate pin, synchronised
	logic        req_prev_ff;                  // Selected line, last cycle
	logic [6:0]  poll_cnt_ff;                  // Ticks to next poll
	logic [15:0] sleep_cnt_ff;                 // Ticks left asleep
	logic [15:0] wake_cnt_ff;                  // Ticks left of forced wake
	logic        polled_ff;                    // Ack seen since wake
	logic        joined_prev_ff;               // Join status, last cycle
	logic        tick;                         // Timer tick enable
	logic        use_alt;                      // Alternate pin drives sleep
	logic        req_line;                     // Selected sleep request
	logic        req_fall;                     // Falling edge of request
	logic        is_pin;                       // Pin sleep selected
	logic        is_cyc;                       // Cyclic sleep selected
	logic        wake_evt;                     // Leaving sleep this cycle
	logic        sleep_expire;                 // Sleep period done
	logic        poll_fire;                    // Issue a poll now
	logic        bus_wr;                       // APB write access
	logic        bus_mapped;                   // Address hits a register

	// ************************************************************
	// Timer tick
	// ************************************************************
	// Restart on wake so polls and timers align to the wake edge
	tick_divider #(
		.DIVIDE    (TICK_DIV)
	) u_tick (
		.i_clock   (i_clock),
		.i_srst    (i_srst),
		.i_restart (wake_evt),                 // see RULE23
		.o_tick    (tick)
	);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Two flops per pin before any logic reads them
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			req_meta_ff <= 1'b0;
			req_sync_ff <= 1'b0;
			alt_meta_ff <= 1'b0;
			alt_sync_ff <= 1'b0;
		end else begin
			req_meta_ff <= i_sleep_request_line;
			req_sync_ff <= req_meta_ff;
			alt_meta_ff <= i_alt_select_pin;
			alt_sync_ff <= alt_meta_ff;
		end
	end

	// Source selection: alternate pin when sleep line disabled and alternate pin enabled
	assign use_alt  = !ctrl_ff.sleep_request_pin_config &&
		ctrl_ff.alt_select_pin_config;  // see RULE19
	assign req_line = use_alt ? alt_sync_ff : req_sync_ff;
	assign req_fall = req_prev_ff && !req_line;

	// Previous request level for edge detection
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			req_prev_ff <= 1'b0;
		end else begin
			req_prev_ff <= req_line;
		end
	end

	// ************************************************************
	// Mode decode
	// ************************************************************
	assign is_pin = ctrl_ff.sleep_mode_select == MODE_PIN;      // see RULE3
	assign is_cyc = ctrl_ff.sleep_mode_select == MODE_CYCLIC ||
		ctrl_ff.sleep_mode_select == MODE_CYC_PIN;              // see RULE4
	assign sleep_expire = tick && sleep_cnt_ff <= 16'h0001;

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Next state from mode, request line, timers and radio activity
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_AWAKE: begin
				// Pin sleep: request high starts the way down
				if (is_pin && req_line) begin
					nxt_state = ST_DRAIN;
				// Cyclic: sleep after an empty poll unless held
				end else if (is_cyc && polled_ff && !o_rx_on &&
					wake_cnt_ff == 16'h0000 && !i_data_seen &&
					!(ctrl_ff.sleep_mode_select == MODE_CYC_PIN &&
					!req_line)) begin  // see RULE21, RULE7
					nxt_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// Host released in pin sleep: stay up
				if (is_pin && !req_line) begin
					nxt_state = ST_AWAKE;
				// Current transfer or join must end first
				end else if (!i_busy) begin            // see RULE17
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (is_pin) begin
					if (!req_line) begin               // see RULE18, RULE7
						nxt_state = ST_AWAKE;
					end
				end else if (ctrl_ff.sleep_mode_select == MODE_CYC_PIN) begin
					if (sleep_expire || req_fall) begin // see RULE6
						nxt_state = ST_AWAKE;
					end
				end else if (ctrl_ff.sleep_mode_select == MODE_CYCLIC) begin
					if (sleep_expire) begin            // see RULE5
						nxt_state = ST_AWAKE;
					end
				end else begin
					// No sleep mode: come back up
					nxt_state = ST_AWAKE;
				end
			end
			default: begin
				nxt_state = ST_AWAKE;
			end
		endcase
	end

	assign wake_evt = state_ff == ST_SLEEP && nxt_state == ST_AWAKE;

	// State register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_ff <= ST_AWAKE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Cyclic timers
	// ************************************************************
	// Sleep period loads on entry, counts ticks while asleep
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sleep_cnt_ff <= 16'h0000;
		end else if (state_ff != ST_SLEEP && nxt_state == ST_SLEEP) begin
			sleep_cnt_ff <= sleep_per_ff;
		end else if (state_ff == ST_SLEEP && tick && sleep_cnt_ff != 16'h0000) begin
			sleep_cnt_ff <= sleep_cnt_ff - 16'h0001;
		end
	end

	// Forced wake time: pin wake, pending data or traffic reload it
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			wake_cnt_ff <= 16'h0000;
		end else if (wake_evt && req_fall) begin
			wake_cnt_ff <= wake_time_ff;               // see RULE6
		end else if (state_ff != ST_SLEEP && (i_data_seen ||
			(i_poll_ack.valid && i_poll_ack.pending))) begin
			wake_cnt_ff <= wake_time_ff;               // see RULE21
		end else if (tick && wake_cnt_ff != 16'h0000) begin
			wake_cnt_ff <= wake_cnt_ff - 16'h0001;
		end
	end

	// ************************************************************
	// Polling
	// ************************************************************
	// First poll on the first tick after wake, then every interval
	assign poll_fire = tick && poll_cnt_ff == 7'h00 && state_ff == ST_AWAKE &&
		(is_pin || is_cyc) && i_joined;

	// Poll interval counter, cleared on each wake
	always_ff @(posedge i_clock) begin
		if (i_srst || wake_evt) begin
			poll_cnt_ff <= 7'h00;                      // see RULE23, RULE20
		end else if (poll_fire) begin
			poll_cnt_ff <= POLL_RELOAD;                // see RULE8
		end else if (tick && poll_cnt_ff != 7'h00) begin
			poll_cnt_ff <= poll_cnt_ff - 7'h01;
		end
	end

	// Poll strobe and receiver window
	always_ff @(posedge i_clock) begin
		if (i_srst || nxt_state == ST_SLEEP) begin
			o_poll_req <= 1'b0;
			o_rx_on    <= 1'b0;
		end else begin
			o_poll_req <= poll_fire;
			if (poll_fire) begin
				o_rx_on <= 1'b1;                       // see RULE9
			end else if (i_poll_ack.valid) begin
				o_rx_on <= i_poll_ack.pending;         // see RULE9
			end else if (i_rx_done) begin
				o_rx_on <= 1'b0;
			end
		end
	end

	// Marks that the wake has seen its poll answered
	always_ff @(posedge i_clock) begin
		if (i_srst || wake_evt) begin
			polled_ff <= 1'b0;
		end else if (i_poll_ack.valid) begin
			polled_ff <= 1'b1;
		end
	end

	// ************************************************************
	// Join and scan
	// ************************************************************
	// Timeout send on join, scan request on unjoined wake
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			joined_prev_ff <= 1'b0;
			o_timeout_send <= 1'b0;
			o_scan_req     <= 1'b0;
		end else begin
			joined_prev_ff <= i_joined;
			o_timeout_send <= i_joined && !joined_prev_ff;  // see RULE2
			o_scan_req     <= wake_evt && !i_joined;        // see RULE16
		end
	end

	assign o_child_timeout = child_to_ff;
	assign o_scan_mask     = scan_mask_ff;

	// ************************************************************
	// Pin outputs
	// ************************************************************
	// Indicators follow the next state so they move with the state
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_awake              <= 1'b1;
			o_cts_n              <= 1'b0;
			o_sleep_pin_pulldown <= 1'b0;
			o_accept_data        <= 1'b1;
		end else begin
			o_awake              <= nxt_state != ST_SLEEP;   // see RULE10, RULE15
			o_cts_n              <= nxt_state == ST_SLEEP &&
				ctrl_ff.flow_control_pin_config;             // see RULE11, RULE15
			o_sleep_pin_pulldown <= nxt_state == ST_SLEEP;   // see RULE13
			o_accept_data        <= nxt_state != ST_SLEEP;   // see RULE14
		end
	end

	// Association output forced low only while asleep
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_assoc <= 1'b0;
		end else if (nxt_state == ST_SLEEP && ctrl_ff.assoc_indicator_config) begin
			o_assoc <= 1'b0;                           // see RULE12
		end else begin
			o_assoc <= i_assoc_led;                    // see RULE15
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	assign bus_wr     = i_psel && i_penable && i_pwrite;
	assign bus_mapped = i_paddr == OFS_CTRL || i_paddr == OFS_WAKE_TIME ||
		i_paddr == OFS_SLEEP_PER || i_paddr == OFS_CHILD_TO ||
		i_paddr == OFS_SCAN_MASK || i_paddr == OFS_STATUS;
	assign o_pready   = 1'b1;
	assign o_pslverr  = i_psel && i_penable && !bus_mapped;

	// Register writes in the access phase
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ctrl_ff      <= ctrl_type'(RST_CTRL);
			wake_time_ff <= RST_WAKE_TIME;
			sleep_per_ff <= RST_SLEEP_PER;
			child_to_ff  <= RST_CHILD_TO;
			scan_mask_ff <= RST_SCAN_MASK;
		end else if (bus_wr) begin
			case (i_paddr)
				OFS_CTRL:      ctrl_ff      <= ctrl_type'(i_pwdata[9:0]);
				OFS_WAKE_TIME: wake_time_ff <= i_pwdata[15:0];
				OFS_SLEEP_PER: sleep_per_ff <= i_pwdata[15:0];
				OFS_CHILD_TO:  child_to_ff  <= i_pwdata[7:0];
				OFS_SCAN_MASK: scan_mask_ff <= i_pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Read data registered in the setup phase
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			case (i_paddr)
				OFS_CTRL:      o_prdata <= {22'h00_0000, ctrl_ff};
				OFS_WAKE_TIME: o_prdata <= {16'h0000, wake_time_ff};
				OFS_SLEEP_PER: o_prdata <= {16'h0000, sleep_per_ff};
				OFS_CHILD_TO:  o_prdata <= {24'h00_0000, child_to_ff};
				OFS_SCAN_MASK: o_prdata <= {16'h0000, scan_mask_ff};
				OFS_STATUS:    o_prdata <= {25'h000_0000, req_line, use_alt,
					o_rx_on, state_ff, i_joined};
				default:       o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_drain_busy;
		state_ff == ST_DRAIN && i_busy && !(is_pin && !req_line);
	endsequence

	sequence s_wake_unjoined;
		wake_evt && !i_joined;
	endsequence

	property p_pin_wake;
		@(posedge i_clock) disable iff (i_srst)
		state_ff == ST_SLEEP && is_pin && !req_line |=> state_ff == ST_AWAKE;
	endproperty
	a_pin_wake: assert property (p_pin_wake)  // see RULE18
		else $error("pin sleep did not wake on low request");

	property p_mode4_no_pin;
		@(posedge i_clock) disable iff (i_srst)
		state_ff == ST_SLEEP && ctrl_ff.sleep_mode_select == MODE_CYCLIC && !sleep_expire
		|=> state_ff == ST_SLEEP;
	endproperty
	a_mode4_no_pin: assert property (p_mode4_no_pin)  // see RULE5
		else $error("mode 4 woke before period expired");

	property p_awake_low;
		@(posedge i_clock) disable iff (i_srst)
		$rose(state_ff == ST_SLEEP) |-> !o_awake && o_sleep_pin_pulldown;
	endproperty
	a_awake_low: assert property (p_awake_low)  // see RULE10
		else $error("awake indicator high in sleep");

	property p_cts_sleep;
		@(posedge i_clock) disable iff (i_srst)
		state_ff == ST_SLEEP && $past(ctrl_ff.flow_control_pin_config) |-> o_cts_n;
	endproperty
	a_cts_sleep: assert property (p_cts_sleep)  // see RULE11
		else $error("clear-to-send not high in sleep");

	property p_assoc_sleep;
		@(posedge i_clock) disable iff (i_srst)
		state_ff == ST_SLEEP && $past(ctrl_ff.assoc_indicator_config) |-> !o_assoc;
	endproperty
	a_assoc_sleep: assert property (p_assoc_sleep)  // see RULE12
		else $error("association output high in sleep");

	property p_no_data_asleep;
		@(posedge i_clock) disable iff (i_srst)
		state_ff == ST_SLEEP |-> !o_accept_data && !o_rx_on && !o_poll_req;
	endproperty
	a_no_data_asleep: assert property (p_no_data_asleep)  // see RULE14
		else $error("data accepted while asleep");

	property p_scan_on_wake;
		@(posedge i_clock) disable iff (i_srst)
		s_wake_unjoined |=> o_scan_req ##1 !o_scan_req;
	endproperty
	a_scan_on_wake: assert property (p_scan_on_wake)  // see RULE16
		else $error("no scan after unjoined wake");

	property p_drain_hold;
		@(posedge i_clock) disable iff (i_srst)
		s_drain_busy |=> state_ff == ST_DRAIN;
	endproperty
	a_drain_hold: assert property (p_drain_hold)  // see RULE17
		else $error("slept during busy transfer");

	property p_rx_after_poll;
		@(posedge i_clock) disable iff (i_srst)
		o_poll_req && !i_poll_ack.valid && !i_rx_done && nxt_state != ST_SLEEP |=> o_rx_on;
	endproperty
	a_rx_after_poll: assert property (p_rx_after_poll)  // see RULE9
		else $error("receiver off after poll");

endmodule

/* tb/host_model.sv */
// Host microcontroller model that drives the sleep request line
module host_model (
	// ************************************************************
	// Ports
	// ************************************************************
	input  wire logic i_clock,
	input  wire logic i_want_sleep,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Host holds the line low to keep awake, high to allow sleep
	always_ff @(posedge i_clock) begin
		o_line <= i_want_sleep;
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the sleep sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sleep_ctl_pkg::*;
	// ************************************************************
	// Signals
	// ************************************************************
	localparam int DIV = 10;                     // Shortened tick divider
	logic i_clock = 0, i_srst = 1, psel = 0, pen = 0, pwr = 0, want = 0;
	logic joined = 0, busy = 0, aled = 0, line;
	logic rxon, scan, tsend, alt = 0;            // Radio side outputs, alternate pin
	logic [15:0] smask;                          // Scan mask out
	logic [7:0] ctimeout;                        // Child timeout out
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, poll, awake, cts_n, assoc, pulld, accept, err;
	ack_type ack = '0;
	int err_count = 0, n_checks = 0, n;
	sleep_ctl #(.TICK_DIV(DIV)) i_sleep_ctl (.i_clock(i_clock), .i_srst(i_srst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_sleep_request_line(line), .i_alt_select_pin(alt),
		.i_joined(joined), .i_busy(busy), .i_poll_ack(ack), .i_rx_done(1'b0), .i_data_seen(1'b0),
		.i_assoc_led(aled), .o_poll_req(poll), .o_rx_on(rxon), .o_scan_req(scan), .o_scan_mask(smask),
		.o_timeout_send(tsend), .o_child_timeout(ctimeout), .o_accept_data(accept), .o_awake(awake),
		.o_cts_n(cts_n), .o_assoc(assoc), .o_sleep_pin_pulldown(pulld));
	host_model i_host_model (.i_clock(i_clock), .i_want_sleep(want), .o_line(line));
	initial forever #20 i_clock = ~i_clock;
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge i_clock);
		pen <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_clock);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0; pen <= 0;
		@(posedge i_clock);
		if (n == 50) begin err_count++; test_done(); end
	endtask
	// Wait for a poll, check the receiver window, answer with nothing pending
	task automatic poll_ack(input int lim);
		for (n = 0; n < lim && poll !== 1'b1; n++) @(posedge i_clock);
		chk(poll, 1, "poll sent");
		chk(rxon, 1, "receiver on after poll");
		ack <= '{valid: 1'b1, pending: 1'b0};
		@(posedge i_clock);
		ack <= '0;
		@(posedge i_clock);
		chk(rxon, 0, "receiver off after empty ack");
	endtask
	// Wait for the awake level to reach v
	task automatic wait_awake(input logic v, input int lim);
		for (n = 0; n < lim && awake !== v; n++) @(posedge i_clock);
		if (n == lim) begin err_count++; test_done(); end
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		apb(0, OFS_CTRL, 0); chk(rd, 32'h0000_0020, "ctrl reset");
		apb(0, 8'h18, 0); chk(rd, 32'h0000_0000, "unmapped data");
		chk(err, 1, "unmapped error");
		// Short cyclic times keep the run brief
		apb(1, OFS_WAKE_TIME, 32'h0000_0005); apb(0, OFS_WAKE_TIME, 0);
		chk(rd, 32'h0000_0005, "wake time");
		chk(err, 0, "mapped error");
		apb(1, OFS_SLEEP_PER, 32'h0000_0008); apb(0, OFS_SLEEP_PER, 0);
		chk(rd, 32'h0000_0008, "sleep period");
		$display("test regs done");
	endtask
	task automatic t_pin();
		joined <= 1; aled <= 1; busy <= 1;
		repeat (2) @(posedge i_clock);
		chk(tsend, 1, "timeout sent on join");
		chk(ctimeout, RST_CHILD_TO, "child timeout");
		apb(1, OFS_CTRL, 32'h0000_0039);
		want <= 1;
		repeat (20) @(posedge i_clock);
		chk(awake, 1, "busy holds awake");
		busy <= 0;
		wait_awake(0, 20);
		@(posedge i_clock);
		chk({cts_n, assoc, pulld, accept}, 4'b1010, "sleep pins");
		want <= 0;
		wait_awake(1, 20);
		@(posedge i_clock);
		chk({cts_n, assoc, accept}, 3'b011, "wake pins");
		poll_ack(DIV + 3);
		for (n = 0; n < 100 * DIV && poll !== 1'b1; n++) @(posedge i_clock);
		chk(n >= 100 * DIV - 3 && n < 100 * DIV, 1, "poll period");
		$display("test pin done");
	endtask
	task automatic t_cyclic();
		apb(1, OFS_CTRL, 32'h0000_0024);
		poll_ack(100 * DIV);
		wait_awake(0, 20);
		want <= 1;
		repeat (5) @(posedge i_clock);
		want <= 0;
		repeat (30) @(posedge i_clock);
		chk(awake, 0, "pin fall ignored");
		wait_awake(1, 100);
		poll_ack(DIV + 3);
		wait_awake(0, 20);
		// Mode 5: a falling request wakes early, unjoined wake scans
		apb(1, OFS_CTRL, 32'h0000_0025);
		joined <= 0; want <= 1;
		repeat (4) @(posedge i_clock);
		want <= 0;
		wait_awake(1, 10);
		chk(scan, 1, "scan on wake");
		chk(smask, RST_SCAN_MASK, "scan mask");
		joined <= 1;
		poll_ack(DIV + 3);
		repeat (80) @(posedge i_clock);
		chk(awake, 1, "line low holds awake");
		want <= 1;
		wait_awake(0, 20);
		$display("test cyclic done");
	endtask
	// Alternate pin replaces the sleep line in pin sleep
	task automatic t_alt();
		apb(1, OFS_CTRL, 32'h0000_0041);
		wait_awake(1, 20);
		alt <= 1;
		wait_awake(0, 20);
		alt <= 0;
		wait_awake(1, 20);
		chk(awake, 1, "alternate pin wake");
		$display("test alt done");
	endtask
	initial begin
		repeat (4) @(posedge i_clock);
		i_srst <= 0;
		@(posedge i_clock);
		t_regs();
		t_pin();
		t_cyclic();
		t_alt();
		test_done();
	end
endmodule
